//--- inc/ocl_params.svh
// Constants of the source current limit and input voltage floor register bank
`ifndef OCL_PARAMS_SVH
`define OCL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OCL_ADDR_OUTV_LO      8'h06
`define OCL_ADDR_CUR_LO       8'h08
`define OCL_ADDR_CUR_HI       8'h09
`define OCL_ADDR_FLR_LO       8'h0a
`define OCL_ADDR_FLR_HI       8'h0b

// ----------------------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------------------
`define OCL_CUR_RESET         16'h3c00
`define OCL_CUR_HI_RSVD_MASK  8'h80
`define OCL_FLR_HI_RSVD_MASK  8'hc0
`define OCL_FLR_LO_POS        6
`define OCL_FLR_RESET         8'h00

// ----------------------------------------------------------------------------
// Weights, offsets and bus address
// ----------------------------------------------------------------------------
`define OCL_CUR_STEP_MA       16'd100
`define OCL_FLR_STEP_SHIFT    6
`define OCL_FLR_OFFSET_MV     16'd3200
`define OCL_FLR_BELOW_MV      16'd1280
`define OCL_FLR_CODE_MAX      8'hff
// Arbitrary bus address, not tied to any real part
`define OCL_DEV_ADDR          7'h09

`endif

//--- inc/ocl_pkg.sv
// Types shared by the register bank and its serial slave
package ocl_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } ocl_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_AACK  = 4'b0010,
        ST_REG   = 4'b0011,
        ST_RACKW = 4'b0100,
        ST_WDATA = 4'b0101,
        ST_WACK  = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_RACK  = 4'b1000
    } ocl_i2c_state_t;

endpackage

//--- logic/ocl_i2c_slave.sv
// Byte-level two-wire bus slave with register pointer and auto-increment
`timescale 1ns/1ps
`default_nettype none
`include "ocl_params.svh"

module ocl_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `OCL_DEV_ADDR
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Bus pins
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_oe,
    // Register side
    output ocl_pkg::ocl_wr_t     wr,
    output logic [7:0]           rd_addr,
    input  wire logic [7:0]      rd_data
);

    ocl_pkg::ocl_i2c_state_t state_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic [7:0] sh_r;
    logic [3:0] cnt_r;
    logic       rw_r;
    logic [7:0] ptr_r;

    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire start_c  = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_c   = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire byte_end = (cnt_r == 4'd8);

    assign rd_addr = ptr_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    // ------------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ocl_pkg::ST_IDLE;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
            rw_r    <= 1'b0;
            ptr_r   <= 8'h00;
            sda_oe  <= 1'b0;
            wr      <= '0;
        end else begin
            wr.valid <= 1'b0;
            if (start_c) begin
                state_r <= ocl_pkg::ST_ADDR;
                cnt_r   <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (stop_c) begin
                state_r <= ocl_pkg::ST_IDLE;
                sda_oe  <= 1'b0;
            end else begin
                case (state_r)
                    ocl_pkg::ST_ADDR, ocl_pkg::ST_REG, ocl_pkg::ST_WDATA: begin
                        if (scl_rise && !byte_end) begin
                            sh_r  <= {sh_r[6:0], sda_in};
                            cnt_r <= cnt_r + 4'd1;
                        end else if (scl_fall && byte_end) begin
                            cnt_r  <= 4'h0;
                            sda_oe <= 1'b1;
                            if (state_r == ocl_pkg::ST_ADDR) begin
                                if (sh_r[7:1] == DEV_ADDR) begin
                                    rw_r    <= sh_r[0];
                                    state_r <= ocl_pkg::ST_AACK;
                                end else begin
                                    sda_oe  <= 1'b0;
                                    state_r <= ocl_pkg::ST_IDLE;
                                end
                            end else if (state_r == ocl_pkg::ST_REG) begin
                                ptr_r   <= sh_r;
                                state_r <= ocl_pkg::ST_RACKW;
                            end else begin
                                wr.valid <= 1'b1;
                                wr.addr  <= ptr_r;
                                wr.data  <= sh_r;
                                state_r  <= ocl_pkg::ST_WACK;
                            end
                        end
                    end
                    ocl_pkg::ST_AACK: begin
                        if (scl_fall) begin
                            if (rw_r) begin
                                sh_r    <= rd_data;
                                sda_oe  <= ~rd_data[7];
                                state_r <= ocl_pkg::ST_RDATA;
                            end else begin
                                sda_oe  <= 1'b0;
                                state_r <= ocl_pkg::ST_REG;
                            end
                        end
                    end
                    ocl_pkg::ST_RACKW, ocl_pkg::ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe  <= 1'b0;
                            state_r <= ocl_pkg::ST_WDATA;
                            if (state_r == ocl_pkg::ST_WACK) begin
                                ptr_r <= ptr_r + 8'h01;
                            end
                        end
                    end
                    ocl_pkg::ST_RDATA: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'd1;
                        end else if (scl_fall) begin
                            if (cnt_r == 4'd8) begin
                                sda_oe  <= 1'b0;
                                cnt_r   <= 4'h0;
                                state_r <= ocl_pkg::ST_RACK;
                            end else begin
                                sda_oe <= ~sh_r[3'd7 - cnt_r[2:0]];
                            end
                        end
                    end
                    ocl_pkg::ST_RACK: begin
                        if (scl_rise) begin
                            rw_r <= ~sda_in;
                        end else if (scl_fall) begin
                            if (rw_r) begin
                                ptr_r   <= ptr_r + 8'h01;
                                state_r <= ocl_pkg::ST_AACK;
                                sh_r    <= 8'h00;
                            end else begin
                                state_r <= ocl_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_r <= ocl_pkg::ST_IDLE;
                        sda_oe  <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // ocl_i2c_slave

`default_nettype wire

//--- logic/ocl_limit_regs.sv
// Source current limit and input voltage floor registers with floor comparator
//
// Notes on behaviour
// - The source current limit is a 7-bit code in bits 6..0 of the high byte, 100 mA per step up to 6400 mA at the top bit.
// - After reset the source current limit pair reads 3C00h.
// - Writes to the current low byte, floor low bits 5..0 and output voltage low bits 1..0 are ignored and these read zero.
// - The input voltage floor is an 8-bit code, high byte bits 5..0 over low byte bits 7..6, 64 mV per step up to 16320 mV.
// - The effective floor threshold is the code weight plus a fixed 3.2 V, even for code zero.
// - When the measured input voltage is below the threshold the block flags input voltage regulation to cut charge current.
// - The default floor is set 1.28 V below the no-load bus voltage rather than to a fixed code.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_params.svh"

module ocl_limit_regs #(
    parameter logic [6:0] DEV_ADDR = `OCL_DEV_ADDR
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Two-wire bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Measured input voltage in mV, no-load value at reset release
    input  wire logic [15:0] vbus_mv,
    // Limits toward the power stage
    output logic [6:0]       cur_limit_code,
    output logic [15:0]      cur_limit_ma,
    output logic [7:0]       floor_code,
    output logic [15:0]      floor_threshold_mv,
    output logic             input_voltage_regulation,
    output logic             invalid_write
);

    ocl_pkg::ocl_wr_t wr;
    logic [7:0]       rd_addr;
    logic [7:0]       rd_data;
    logic             sda_oe_i;
    logic [6:0]       limit_r;
    logic [7:0]       floor_r;
    logic [1:0]       stage_r;
    logic             stage_vld_r;
    logic             init_pending_r;
    logic [15:0]      thr_nxt;
    logic [7:0]       init_code;

    localparam logic [15:0] CUR_RST = `OCL_CUR_RESET;

    // ------------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------------
    ocl_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .ref_clk (ref_clk),
        .rst     (rst),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_oe  (sda_oe_i),
        .wr      (wr),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // ------------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------------
    function automatic logic rsvd_hit(input logic [7:0] addr, input logic [7:0] data);
        rsvd_hit = ((addr == `OCL_ADDR_CUR_HI) && ((data & `OCL_CUR_HI_RSVD_MASK) != 8'h00)) ||
                   ((addr == `OCL_ADDR_FLR_HI) && ((data & `OCL_FLR_HI_RSVD_MASK) != 8'h00));
    endfunction

    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [6:0] lim,
                                            input logic [7:0] flr);
        case (addr)
            `OCL_ADDR_CUR_HI: reg_read = {1'b0, lim};
            `OCL_ADDR_FLR_HI: reg_read = {2'b00, flr[7:2]};
            `OCL_ADDR_FLR_LO: reg_read = {flr[1:0], 6'h00};
            default:          reg_read = 8'h00;
        endcase
    endfunction

    assign rd_data = reg_read(rd_addr, limit_r, floor_r);

    // Floor code that puts the threshold 1.28 V under the no-load voltage
    always_comb begin
        logic [15:0] drop;
        drop = `OCL_FLR_OFFSET_MV + `OCL_FLR_BELOW_MV;
        if (vbus_mv <= drop) begin
            init_code = 8'h00;
        end else if (((vbus_mv - drop) >> `OCL_FLR_STEP_SHIFT) > 16'(`OCL_FLR_CODE_MAX)) begin
            init_code = `OCL_FLR_CODE_MAX;
        end else begin
            init_code = 8'((vbus_mv - drop) >> `OCL_FLR_STEP_SHIFT);
        end
    end

    assign thr_nxt = `OCL_FLR_OFFSET_MV + (16'(floor_r) << `OCL_FLR_STEP_SHIFT);

    // ------------------------------------------------------------------------
    // Source current limit
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            limit_r <= CUR_RST[14:8];
        end else if (wr.valid && wr.addr == `OCL_ADDR_CUR_HI && !rsvd_hit(wr.addr, wr.data)) begin
            limit_r <= wr.data[6:0];
        end
    end

    // ------------------------------------------------------------------------
    // Input voltage floor
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            init_pending_r <= 1'b1;
            floor_r        <= `OCL_FLR_RESET;
            stage_r        <= 2'b00;
            stage_vld_r    <= 1'b0;
        end else if (init_pending_r) begin
            init_pending_r <= 1'b0;
            floor_r        <= init_code;
        end else if (wr.valid && wr.addr == `OCL_ADDR_FLR_LO) begin
            stage_r     <= wr.data[`OCL_FLR_LO_POS +: 2];
            stage_vld_r <= 1'b1;
        end else if (wr.valid && wr.addr == `OCL_ADDR_FLR_HI) begin
            stage_vld_r <= 1'b0;
            if (!rsvd_hit(wr.addr, wr.data)) begin
                floor_r <= {wr.data[5:0], stage_vld_r ? stage_r : floor_r[1:0]};
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_limit_code           <= CUR_RST[14:8];
            cur_limit_ma             <= 16'h0000;
            floor_code               <= `OCL_FLR_RESET;
            floor_threshold_mv       <= `OCL_FLR_OFFSET_MV;
            input_voltage_regulation <= 1'b0;
        end else begin
            cur_limit_code           <= limit_r;
            cur_limit_ma             <= 16'(limit_r) * `OCL_CUR_STEP_MA;
            floor_code               <= floor_r;
            floor_threshold_mv       <= thr_nxt;
            input_voltage_regulation <= !init_pending_r && (vbus_mv < thr_nxt);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            invalid_write <= 1'b0;
            sda_oe        <= 1'b0;
            sda_out       <= 1'b0;
        end else begin
            invalid_write <= wr.valid && rsvd_hit(wr.addr, wr.data);
            sda_oe        <= sda_oe_i;
            sda_out       <= 1'b0;
        end
    end

endmodule // ocl_limit_regs

`default_nettype wire

//--- testbench/ocl_host_model.sv
// Two-wire bus host that writes and reads the register bank
`timescale 1ns/1ps
`default_nettype none
`include "ocl_params.svh"

module ocl_host_model (
    // Clock
    input  wire logic  ref_clk,
    // Bus pins, data released means pulled up
    input  wire logic  sda_line,
    output logic       scl,
    output logic       sda_drv,
    // Read results
    output logic       rd_valid,
    output logic [7:0] rd_byte
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        rd_valid = 1'b0;
        rd_byte = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Each clock phase spans 4 or 5 cycles
    task automatic put_bit(input logic b, output logic r);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_line;
        scl = 1'b0;
        tick(1);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask
    task automatic send(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) put_bit(d[i], nack);
        put_bit(1'b1, nack);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                      input int n, output logic nack);
        logic [7:0] b[3] = '{a, d0, d1};
        logic       k;
        start();
        send({dev, 1'b0}, nack);
        for (int i = 0; i <= n && !nack; i++) begin
            send(b[i], k);
            nack = k;
        end
        stop();
    endtask
    task automatic rd(input logic [7:0] a);
        logic       k;
        logic [7:0] d;
        start();
        send({`OCL_DEV_ADDR, 1'b0}, k);
        send(a, k);
        start();
        send({`OCL_DEV_ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(1'b1, k);
        stop();
        rd_byte = d;
        rd_valid = 1'b1;
        tick(1);
        rd_valid = 1'b0;
    endtask
endmodule // ocl_host_model
`default_nettype wire

//--- testbench/ocl_limit_regs_sva.sv
// Checker for the source current limit and input voltage floor register bank
`timescale 1ns/1ps
`default_nettype none

module ocl_limit_regs_sva (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Two-wire bus pins
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    // Measured voltage and limits
    input wire logic [15:0] vbus_mv,
    input wire logic [6:0]  cur_limit_code,
    input wire logic [15:0] cur_limit_ma,
    input wire logic [7:0]  floor_code,
    input wire logic [15:0] floor_threshold_mv,
    input wire logic        input_voltage_regulation,
    input wire logic        invalid_write
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_ma_tracks_code: assert property (!$past(rst) |-> cur_limit_ma == (16'(cur_limit_code) * 16'd100))
        else $error("current in mA does not follow the code");
    a_thr_tracks_code: assert property (!$past(rst) |-> floor_threshold_mv == 16'd3200 + (16'(floor_code) << 6))
        else $error("floor threshold does not follow the code");
    a_reg_compare: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) && $stable(vbus_mv)
        && $stable(floor_code) && floor_code == $past(floor_code, 2)
        |-> input_voltage_regulation == (vbus_mv < floor_threshold_mv)) else $error("regulation flag wrong");
    a_inv_pulse_one: assert property (invalid_write |=> !invalid_write)
        else $error("invalid write pulse longer than one cycle");
    a_inv_still_ack: assert property (invalid_write |-> ##[0:4] sda_oe)
        else $error("invalid write byte not acknowledged");
    a_inv_no_effect: assert property (invalid_write |-> ($stable(cur_limit_code) && $stable(floor_code))[*5])
        else $error("invalid write changed a limit");
    a_cur_on_ack: assert property ($changed(cur_limit_code) |-> sda_oe || $past(sda_oe))
        else $error("current code changed outside a write");
    a_floor_on_ack: assert property (!$past(rst, 2) && !$past(rst, 3) && $changed(floor_code)
        |-> sda_oe || $past(sda_oe)) else $error("floor code changed outside a write");
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("data pin driven high");

    cover property (invalid_write);
    cover property ($rose(input_voltage_regulation));
    cover property ($changed(cur_limit_code));
    cover property ($changed(floor_code));
endmodule // ocl_limit_regs_sva

bind ocl_limit_regs ocl_limit_regs_sva u_sva (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .vbus_mv(vbus_mv), .cur_limit_code(cur_limit_code),
    .cur_limit_ma(cur_limit_ma), .floor_code(floor_code), .floor_threshold_mv(floor_threshold_mv),
    .input_voltage_regulation(input_voltage_regulation), .invalid_write(invalid_write));
`default_nettype wire

//--- testbench/test_ocl_limit_regs.sv
// Self-checking testbench of the limit register bank
`timescale 1ns/1ps
`default_nettype none
`include "ocl_params.svh"

module test_ocl_limit_regs;
    logic        ref_clk;
    logic        rst;
    logic [15:0] vbus_mv;
    logic        scl, sda_drv, sda_line, sda_out, sda_oe, rd_valid, inv_w, reg_o, nack;
    logic [7:0]  rd_byte, fcode;
    logic [6:0]  ccode;
    logic [15:0] cma, thr;
    logic [7:0]  exp_q[$];
    int          errors, num_checks, inv_cnt, seed;

    assign sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    ocl_limit_regs DUT (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .vbus_mv(vbus_mv), .cur_limit_code(ccode), .cur_limit_ma(cma), .floor_code(fcode),
        .floor_threshold_mv(thr), .input_voltage_regulation(reg_o), .invalid_write(inv_w));
    ocl_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
        .rd_valid(rd_valid), .rd_byte(rd_byte));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n);
        host.wr(`OCL_DEV_ADDR, a, d0, d1, n, nack);
        check("write ack", {15'h0, nack}, 16'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task automatic outs(input logic [6:0] c, input logic [7:0] f);
        check("cur_limit_code", 16'(ccode), 16'(c));
        check("cur_limit_ma", cma, 16'(c) * 16'd100);
        check("floor_code", 16'(fcode), 16'(f));
        check("floor_threshold_mv", thr, 16'd3200 + (16'(f) << 6));
    endtask

    // Read results compared against the oldest expectation
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) check("read byte", 16'(rd_byte), 16'(exp_q.pop_front()));
        if (inv_w === 1'b1) inv_cnt++;
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        logic [6:0]  c;
        logic [7:0]  f;
        logic [15:0] vt[4] = '{16'd3100, 16'd3300, 16'd4000, 16'd5000};
        seed = 32'hd88ff73f;
        rst = 1'b1;
        vbus_mv = 16'd5000;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        f = 8'((16'd5000 - 16'd4480) >> 6);
        outs(7'h3c, f);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h3c);
        rd(8'h0a, {f[1:0], 6'h00});
        rd(8'h0b, {2'b00, f[7:2]});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 7'h7f : 7'($random(seed));
            f = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            wr(8'h09, {1'b0, c}, 8'h00, 1);
            wr(8'h0a, {f[1:0], 6'h3f}, {2'b00, f[7:2]}, 2);
            outs(c, f);
            rd(8'h09, {1'b0, c});
            rd(8'h0a, {f[1:0], 6'h00});
            rd(8'h0b, {2'b00, f[7:2]});
        end
        $display("test limits done");
        wr(8'h08, 8'hff, 8'h00, 1);
        wr(8'h06, 8'h03, 8'h00, 1);
        rd(8'h08, 8'h00);
        rd(8'h06, 8'h00);
        wr(8'h09, 8'h80 | 8'(c), 8'h00, 1);
        wr(8'h0b, 8'h41, 8'h00, 1);
        check("invalid count", 16'(inv_cnt), 16'h0002);
        outs(c, f);
        host.wr(`OCL_DEV_ADDR ^ 7'h40, 8'h09, 8'h01, 8'h00, 1, nack);
        check("foreign address nack", {15'h0, nack}, 16'h0001);
        check("limit after foreign write", 16'(ccode), 16'(c));
        $display("test refusals done");
        for (int i = 0; i < 4; i++) begin
            f = (i < 2) ? 8'h00 : 8'h10;
            wr(8'h0a, {f[1:0], 6'h00}, {2'b00, f[7:2]}, 2);
            vbus_mv = vt[i];
            repeat (4) @(posedge ref_clk);
            #1;
            check("regulation", 16'(reg_o), 16'(!i[0]));
        end
        $display("test regulation done");
        repeat (4) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule // test_ocl_limit_regs
`default_nettype wire
